// file: supply_irq_pkg.sv
package supply_irq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_EN_CLEAR = 8'h00;
  localparam logic [7:0] OFS_EN_SET = 8'h04;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  ////////////////////////////////////////////////////////////////////////////
  // source count and internal index of each source
  localparam int N_SRC = 6;
  localparam int IDX_DETECTOR_READY = 0;
  localparam int IDX_BROWNOUT = 1;
  localparam int IDX_SYNC_READY = 2;
  localparam int IDX_REGULATOR_READY = 3;
  localparam int IDX_SWITCH_READY = 4;
  localparam int IDX_CORE_READY = 5;

  // bit position of each source inside a register word
  localparam int POS_DETECTOR_READY = 0;
  localparam int POS_BROWNOUT = 1;
  localparam int POS_SYNC_READY = 2;
  localparam int POS_REGULATOR_READY = 8;
  localparam int POS_SWITCH_READY = 9;
  localparam int POS_CORE_READY = 10;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset and synchroniser depth
  localparam logic [5:0] ENABLE_RESET = 6'h00;
  localparam logic [5:0] FLAG_RESET = 6'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam int SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // pack internal source vector into a register word, unused bits zero
  function automatic logic [31:0] to_word(input logic [5:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[POS_DETECTOR_READY] = v[IDX_DETECTOR_READY];
    w[POS_BROWNOUT] = v[IDX_BROWNOUT];
    w[POS_SYNC_READY] = v[IDX_SYNC_READY];
    w[POS_REGULATOR_READY] = v[IDX_REGULATOR_READY];
    w[POS_SWITCH_READY] = v[IDX_SWITCH_READY];
    w[POS_CORE_READY] = v[IDX_CORE_READY];
    return w;
  endfunction : to_word

  // pick source bits out of a register word, other bits dropped
  function automatic logic [5:0] from_word(input logic [31:0] w);
    logic [5:0] v;
    v = 6'h00;
    v[IDX_DETECTOR_READY] = w[POS_DETECTOR_READY];
    v[IDX_BROWNOUT] = w[POS_BROWNOUT];
    v[IDX_SYNC_READY] = w[POS_SYNC_READY];
    v[IDX_REGULATOR_READY] = w[POS_REGULATOR_READY];
    v[IDX_SWITCH_READY] = w[POS_SWITCH_READY];
    v[IDX_CORE_READY] = w[POS_CORE_READY];
    return v;
  endfunction : from_word

  // widen byte strobes into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : lane_mask

endpackage : supply_irq_pkg

// file: edge_sync.sv
`timescale 1ns/1ps
module edge_sync #(
  parameter int W = 6
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out
);

  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] sync_q, sync_d;
  logic [W-1:0] prev_q, prev_d;

  ////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage, never the edge detector
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // zero-to-one on the settled level
  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;

endmodule : edge_sync

// file: supply_irq_enable.sv
`timescale 1ns/1ps
module supply_irq_enable (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_protect_on,
  input wire logic [5:0] status_in,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [5:0] enable_q, enable_d;
  logic [5:0] flags_q, flags_d;
  logic irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic err_q, err_d;

  logic [5:0] status_lvl;
  logic [5:0] status_rise;

  logic access;
  logic wr;
  logic hit_clear;
  logic hit_set;
  logic hit_flags;
  logic blocked;
  logic [5:0] wbits;
  logic [5:0] src_req;

  ////////////////////////////////////////////////////////////////////////////
  // timing at a glance
  // setup cycle: psel high, penable low, nothing is decoded yet
  // access cycle: psel and penable high, pready still low
  // the edge that ends the access cycle commits writes and captures reads
  // the cycle after it shows pready, with pslverr for a refused write
  // so every access costs exactly one wait state, never more
  // ready_q masks the access term only in the pready cycle, so penable
  // held past that cycle commits the same write a second time
  // read data holds until the next read, which keeps prdata a plain flop
  // reads always return the full word, strobes only steer writes
  // protection gates only the two enable offsets, flags stay clearable
  // status path: two synchroniser flops, then one edge compare
  // a flag shows three edges after its status input rises
  // irq follows a flag or enable change on the edge that makes it
  // a status input already high at reset release reads as a new rise
  // limitation: a status pulse shorter than a clock may be missed
  // limitation: flags always start from zero, no preset values
  // trade-off: one wait state costs bus time but registers every output
  // unmapped offsets read zero and complete without an error
  // the status offset reflects synchronised levels, not raw pins
  // writes to the status offset are ignored
  // paddr is compared in full, so the low two bits must be zero
  // byte strobes mask the write word before the bit extraction
  // so a narrow access touches only the lanes it names

  ////////////////////////////////////////////////////////////////////////////
  // status inputs come from other supply domains, so synchronise first

  edge_sync #(
    .W(supply_irq_pkg::N_SRC)
  ) u_status_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(status_in),
    .level_out(status_lvl),
    .rise_out(status_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; one wait state so every output can be a flop

  assign access = psel & penable & ~ready_q;
  assign wr = access & pwrite;
  assign hit_clear = (paddr == supply_irq_pkg::OFS_EN_CLEAR);
  assign hit_set = (paddr == supply_irq_pkg::OFS_EN_SET);
  assign hit_flags = (paddr == supply_irq_pkg::OFS_EVENT_FLAGS);

  assign blocked = write_protect_on & (hit_clear | hit_set);

  assign wbits = supply_irq_pkg::from_word(pwdata & supply_irq_pkg::lane_mask(pstrb));

  ////////////////////////////////////////////////////////////////////////////
  // enable bits
  // one shared vector behind both offsets, so set and clear never disagree

  always_comb begin
    enable_d = enable_q;
    if (wr && !blocked && hit_clear) begin
      enable_d = enable_q & ~wbits;
    end
    if (wr && !blocked && hit_set) begin
      enable_d = enable_q | wbits;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= supply_irq_pkg::ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flags
  // a rise in the clear cycle wins, else software could lose an event

  always_comb begin
    flags_d = flags_q;
    if (wr && hit_flags) begin
      flags_d = flags_q & ~wbits;
    end
    flags_d = flags_d | status_rise;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= supply_irq_pkg::FLAG_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request
  // built from next values, so irq moves on the same edge as the registers

  always_comb begin
    src_req = flags_d & enable_d;
    irq_d = |src_req;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and completion; unmapped reads return zero, no error

  always_comb begin
    rdata_d = rdata_q;
    ready_d = access;
    // protected writes complete with an error so software notices
    err_d = wr & blocked;
    if (access && !pwrite) begin
      case (paddr)
        // both enable offsets read the same bits
        supply_irq_pkg::OFS_EN_CLEAR: begin
          rdata_d = supply_irq_pkg::to_word(enable_q);
        end
        supply_irq_pkg::OFS_EN_SET: begin
          rdata_d = supply_irq_pkg::to_word(enable_q);
        end
        supply_irq_pkg::OFS_EVENT_FLAGS: begin
          rdata_d = supply_irq_pkg::to_word(flags_q);
        end
        supply_irq_pkg::OFS_STATUS: begin
          rdata_d = supply_irq_pkg::to_word(status_lvl);
        end
        default: begin
          rdata_d = supply_irq_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= supply_irq_pkg::RDATA_RESET;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign irq = irq_q;

endmodule : supply_irq_enable

// file: supply_irq_enable_sva.sv
`timescale 1ns/1ps
module supply_irq_enable_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic write_protect_on,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic en_rd;
  // enable register read completing
  assign en_rd = pready && !pwrite && (paddr == 8'h00 || paddr == 8'h04);
  //////////////////////////////////////////////////////////////////////////////
  AST_ACK_ONE: assert property (pready |=> !pready)
    else $error("pready wider than one cycle");
  AST_ACK_TIME: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not one cycle after access");
  AST_PROT_ERR: assert property (pready && pwrite && write_protect_on && paddr == 8'h04
    |-> pslverr)
    else $error("protected write not refused");
  AST_UNUSED_ZERO: assert property (en_rd |-> prdata[31:11] == 21'h0 && prdata[7:3] == 5'h0)
    else $error("unused enable bits not zero");
  AST_RST_QUIET: assert property ($rose(rst_b) |-> !irq && !pready)
    else $error("outputs active after reset");
  AST_IRQ_HOLD: assert property (irq && !psel |=> irq)
    else $error("irq dropped without cause");
  AST_EN_IRQ: assert property (en_rd && prdata == 32'h0 |-> !irq)
    else $error("irq with no enable set");
  // flags were captured one edge before pready, so compare irq of that edge
  AST_FLAG_IRQ: assert property (pready && !pwrite && paddr == 8'h08 && prdata == 32'h0
    |-> !$past(irq))
    else $error("irq with no flag set");
  // main scenarios reached
  cover property (pready && pslverr);
  cover property (pready && !pwrite && paddr == 8'h0c);
  cover property ($rose(irq));
  cover property ($fell(irq) && psel);
endmodule : supply_irq_enable_chk

bind supply_irq_enable supply_irq_enable_chk i_supply_irq_enable_chk (.ref_clk, .rst_b,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .write_protect_on, .irq);

// file: supply_irq_enable_test.sv
`timescale 1ns/1ps
module supply_irq_enable_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic write_protect_on = 1'b0;
  logic [5:0] status_in = 6'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  int mismatches = 0;
  int n_compared = 0;
  // free running bus clock
  always #50 ref_clk = ~ref_clk;
  supply_irq_enable i_supply_irq_enable (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pstrb, .pwdata, .prdata, .pready, .pslverr, .write_protect_on, .status_in, .irq);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one bus access; held until the edge after pready, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pstrb = s;
    pwdata = d;
    @(negedge ref_clk);
    penable = 1'b1;
    do begin
      @(negedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("Error pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    @(negedge ref_clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 4'hf, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_set_clear();
    rdc(8'h04, 32'h0, "en_reset");
    bus(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
    rdc(8'h00, 32'h0000_0707, "en_all");
    bus(1'b1, 8'h00, 4'hf, 32'h0000_0002);
    rdc(8'h04, 32'h0000_0705, "en_clr1");
    // byte lane write must leave lane 0 alone
    bus(1'b1, 8'h00, 4'h2, 32'hffff_ffff);
    rdc(8'h04, 32'h0000_0005, "en_lane");
    // half word set, then lane 1 clear restores the state
    bus(1'b1, 8'h04, 4'h3, 32'h0000_0100);
    rdc(8'h00, 32'h0000_0105, "en_half");
    bus(1'b1, 8'h00, 4'h2, 32'h0000_0100);
    // upper half strobes carry no enable bits
    bus(1'b1, 8'h04, 4'hc, 32'hffff_ffff);
    chk("slverr_free", 32'h0, {31'h0, err});
    rdc(8'h04, 32'h0000_0005, "en_upper");
  endtask : t_set_clear
  task automatic t_protect();
    write_protect_on = 1'b1;
    bus(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
    chk("slverr", 32'h1, {31'h0, err});
    write_protect_on = 1'b0;
    rdc(8'h00, 32'h0000_0005, "en_prot");
  endtask : t_protect
  // flag wait is the fixed sync plus edge detect latency
  task automatic t_irq();
    status_in[0] = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    rdc(8'h08, 32'h0000_0001, "flags");
    bus(1'b1, 8'h00, 4'h1, 32'h0000_0001);
    chk("irq_dis", 32'h0, {31'h0, irq});
    bus(1'b1, 8'h04, 4'h1, 32'h0000_0001);
    chk("irq_en", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h08, 4'h1, 32'h0000_0001);
    chk("irq_flag", 32'h0, {31'h0, irq});
    status_in[1] = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("irq_mask", 32'h0, {31'h0, irq});
    rdc(8'h08, 32'h0000_0002, "flags_mask");
    rdc(8'h0c, 32'h0000_0003, "status");
  endtask : t_irq
  // reset in mid-run while a request stands
  task automatic t_reset();
    bus(1'b1, 8'h04, 4'h1, 32'h0000_0002);
    chk("irq_pre", 32'h1, {31'h0, irq});
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk("irq_rst", 32'h0, {31'h0, irq});
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    rdc(8'h04, 32'h0, "en_rst2");
    repeat (4) @(negedge ref_clk);
    chk("irq_after", 32'h0, {31'h0, irq});
  endtask : t_reset
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // main sequence after a 20 cycle reset
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    t_set_clear();
    t_protect();
    t_irq();
    t_reset();
    wrap_up();
  end
  // watchdog, far beyond the roughly 120 cycles needed
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end
endmodule : supply_irq_enable_test
